// >>> src/pcr_pkg.sv
// package for the processor control register group
package pcr_pkg;

	// register addresses
	localparam logic [15:0] ADDR_CLK_DIV = 16'hc008;
	localparam logic [15:0] ADDR_PWR = 16'hc00a;
	localparam logic [15:0] ADDR_IRQ_EN = 16'hc00e;
	localparam logic [15:0] ADDR_BRK = 16'hc014;
	localparam logic [15:0] ADDR_DIAG = 16'hc03c;

	// writable masks and reset values
	localparam logic [15:0] CLK_DIV_MASK = 16'h000f;
	localparam logic [15:0] CLK_DIV_RESET = 16'h000f;
	localparam logic [15:0] PWR_MASK = 16'h5b93;
	localparam logic [15:0] PWR_RESET = 16'h0000;
	localparam logic [15:0] IRQ_EN_MASK = 16'h1bef;
	localparam logic [15:0] IRQ_EN_RESET = 16'h0000;
	localparam logic [15:0] BRK_RESET = 16'h0000;
	localparam logic [15:0] DIAG_MASK = 16'h5077;
	localparam logic [15:0] DIAG_RESET = 16'h0000;

	// power control fields
	localparam int PWR_HALT = 0;
	localparam int PWR_SLEEP = 1;
	localparam int PWR_BOOST = 2;
	localparam int PWR_PIN_WAKE = 4;
	localparam int PWR_HOST_WAKE = 7;
	localparam int PWR_SPI_WAKE = 8;
	localparam int PWR_FSP_WAKE = 9;
	localparam int PWR_OTG_WAKE = 11;
	localparam int PWR_SE1_WAKE = 12;
	localparam int PWR_SE2_WAKE = 14;

	// interrupt enable fields
	localparam int IE_TM0 = 0;
	localparam int IE_TM1 = 1;
	localparam int IE_GPIO = 2;
	localparam int IE_UART = 3;
	localparam int IE_OUTBOUND_MAILBOX_IRQ = 5;
	localparam int IE_INBOUND_MAILBOX_IRQ = 6;
	localparam int IE_FSP = 7;
	localparam int IE_SE1 = 8;
	localparam int IE_SE2 = 9;
	localparam int IE_SPI = 11;
	localparam int IE_OTG = 12;

	// diagnostic fields
	localparam int DG_P1 = 12;
	localparam int DG_P2 = 14;
	localparam int DG_FS_PU = 4;
	localparam int DG_LS_PU = 5;
	localparam int DG_PD = 6;
	localparam int DG_SE0 = 2;
	localparam int DG_JK = 1;

	// timing
	localparam int CLK_HZ = 50_000_000;
	localparam int RESUME_US = 500;
	localparam int RESUME_CYC = (CLK_HZ / 1_000_000) * RESUME_US;
	localparam int WAKE_CYC = 64;

	typedef enum logic [1:0] {
		PM_RUN = 2'b00,
		PM_HALT = 2'b01,
		PM_SLEEP = 2'b10,
		PM_WAKE = 2'b11
	} pcr_pm_e;

	// register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic host;
		logic [15:0] addr;
		logic [15:0] wdata;
	} pcr_req_s;

	// interrupt sources grouped
	typedef struct packed {
		logic [5:0] se2;
		logic [5:0] se1;
		logic [2:0] spi;
		logic [1:0] fsp;
		logic [1:0] uart;
		logic otg;
		logic inbound_mailbox_irq;
		logic outbound_mailbox_irq;
		logic gpio;
		logic tm1;
		logic tm0;
	} pcr_irq_s;

	// usb line test drive for one port
	typedef struct packed {
		logic active;
		logic pull_down;
		logic ls_pull_up;
		logic fs_pull_up;
		logic se0;
		logic jk;
		logic j_not_k;
	} pcr_line_s;

endpackage

// >>> src/pcr_regs.sv
// processor control registers: clock divisor, power, irq, breakpoint, diag
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Overview of operation
// [RULE1] cpu divisor only gates the core, peripherals keep the full clock
// [RULE2] core runs one cycle in speed field plus one
// [RULE3] sleep bit write stops clock, powers down boost, pump, transceivers
// [RULE4] counters and timers freeze in sleep and keep their values
// [RULE5] enabled wake activity ends sleep; execution resumes within 0.5 ms
// [RULE6] halt bit write stops only the core
// [RULE7] any enabled interrupt ends halt
// [RULE8] software follows halt with two no-operation instructions
// [RULE9] bits 14 and 12 wake on serial engine 2 or 1, no interrupt
// [RULE10] bit 11 wakes on otg vbus valid or id transition
// [RULE11] bit 9 wakes on fast serial rx, bit 8 on slave select fall
// [RULE12] the byte that woke fast serial or spi is discarded
// [RULE13] bit 7 wakes on host port read, bit 4 on pins 25 or 24
// [RULE14] bit 2 reads one while boost not ready and rails low
// [RULE15] enable bits 9 and 8 gate all serial engine 2 or 1 interrupts
// [RULE16] bit 11 gates spi, bit 7 fast serial, bit 3 uart interrupts
// [RULE17] bit 12 gates otg, bit 6 inbound, bit 5 outbound mailbox
// [RULE18] clearing pin, timer 1 or timer 0 enable clears their pending
// [RULE19] pc equal to breakpoint raises vector 127; zero write clears it
// [RULE20] diag register readable on chip, write-only from host port
// [RULE21] diag bits 14 and 12 apply test conditions to port 2a or 1a
// [RULE22] bit 6 pull-downs, bit 5 low-speed pull-up, bit 4 full-speed
// [RULE23] force code 1xx drives se0, 01x toggles j and k
// [RULE24] software writes zero to reserved bits
// [RULE25] a read that wakes from sleep returns throwaway data
// [RULE26] breakpoint is inactive while its register holds zero
// ---------------------------------------------------------------
module pcr_regs
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// register access
	input wire pcr_pkg::pcr_req_s req_i,
	output logic [15:0] rdata_o,
	output logic rvalid_o,
	// processor side
	input wire logic [15:0] pc_i,
	output logic cpu_run_o,
	output logic periph_run_o,
	output logic breakpoint_vector_o,
	// interrupt sources, gated outputs and pending clears
	input wire pcr_pkg::pcr_irq_s irq_i,
	output pcr_pkg::pcr_irq_s irq_o,
	output logic first_timer_clr_o,
	output logic second_timer_clr_o,
	output logic gpio_clr_o,
	// wake inputs and boost status from pins
	input wire logic se1_line_i,
	input wire logic se2_line_i,
	input wire logic otg_vbus_valid_i,
	input wire logic otg_id_i,
	input wire logic fast_serial_port_rx_i,
	input wire logic serial_slave_select_n_i,
	input wire logic [1:0] pin_wake_i,
	input wire logic boost_not_ok_i,
	// power and byte discard
	output logic boost_on_o,
	output logic charge_pump_on_o,
	output logic transceiver_on_o,
	output logic discard_byte_o,
	// line test
	output pcr_pkg::pcr_line_s port1_line_o,
	output pcr_pkg::pcr_line_s port2_line_o
);

	// ---------------------------------------------------------------
	// synchronisers
	// ---------------------------------------------------------------
	logic [8:0] sync1_r;
	logic [8:0] sync2_r;
	logic [8:0] prev_r;
	logic [8:0] pins_raw;

	// pin order: se2, boost, wake pins, select, rx, id, vbus, se1
	assign pins_raw = {se2_line_i, boost_not_ok_i, pin_wake_i,
		serial_slave_select_n_i, fast_serial_port_rx_i, otg_id_i,
		otg_vbus_valid_i, se1_line_i};

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			sync1_r <= 9'h000;
			sync2_r <= 9'h000;
			prev_r <= 9'h000;
		end
		else
		begin
			sync1_r <= pins_raw;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	// ---------------------------------------------------------------
	// registers and power state
	// ---------------------------------------------------------------
	logic [15:0] div_r, div_nxt;
	logic [15:0] pwr_r, pwr_nxt;
	logic [15:0] ie_r, ie_nxt;
	logic [15:0] brk_r, brk_nxt;
	logic [15:0] diag_r, diag_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [15:0] res_r, res_nxt;
	logic brk_hit_r, brk_hit_nxt;
	pcr_pkg::pcr_pm_e pm_r, pm_nxt;
	logic [15:0] rdata_nxt;
	logic rvalid_nxt;
	logic cpu_run_r;
	logic cpu_run_nxt;
	logic discard_nxt;
	logic discard_r;
	pcr_pkg::pcr_irq_s irq_nxt;
	logic [2:0] clr_nxt;
	logic [2:0] clr_r;
	logic jk_r, jk_nxt;
	logic wake;
	logic any_irq;
	logic [8:0] edge_s;

	function automatic logic [15:0] masked(input logic [15:0] v,
		input logic [15:0] m);
		masked = v & m;
	endfunction

	function automatic logic hit(input logic [15:0] a);
		hit = req_i.addr == a;
	endfunction

	assign edge_s = sync2_r ^ prev_r;

	always_comb
	begin
		div_nxt = div_r;
		pwr_nxt = pwr_r;
		ie_nxt = ie_r;
		brk_nxt = brk_r;
		diag_nxt = diag_r;
		cnt_nxt = cnt_r;
		res_nxt = res_r;
		pm_nxt = pm_r;
		brk_hit_nxt = brk_hit_r;
		rdata_nxt = 16'h0000;
		rvalid_nxt = 1'b0;
		discard_nxt = 1'b0;
		clr_nxt = 3'b000;
		jk_nxt = ~jk_r;
		// wake sources, serial engine edges raise no interrupt
		wake = (pwr_r[pcr_pkg::PWR_SE1_WAKE] & edge_s[0]) // RULE9
			| (pwr_r[pcr_pkg::PWR_SE2_WAKE] & edge_s[8])
			| (pwr_r[pcr_pkg::PWR_OTG_WAKE] & (edge_s[1] | edge_s[2])) // RULE10
			| (pwr_r[pcr_pkg::PWR_FSP_WAKE] & edge_s[3]) // RULE11
			| (pwr_r[pcr_pkg::PWR_SPI_WAKE] & edge_s[4] & ~sync2_r[4])
			| (pwr_r[pcr_pkg::PWR_HOST_WAKE] & req_i.rd & req_i.host) // RULE13
			| (pwr_r[pcr_pkg::PWR_PIN_WAKE] & (edge_s[5] | edge_s[6]));
		irq_nxt = irq_i;
		irq_nxt.se1 = irq_i.se1 & {6{ie_r[pcr_pkg::IE_SE1]}}; // RULE15
		irq_nxt.se2 = irq_i.se2 & {6{ie_r[pcr_pkg::IE_SE2]}};
		irq_nxt.spi = irq_i.spi & {3{ie_r[pcr_pkg::IE_SPI]}}; // RULE16
		irq_nxt.fsp = irq_i.fsp & {2{ie_r[pcr_pkg::IE_FSP]}};
		irq_nxt.uart = irq_i.uart & {2{ie_r[pcr_pkg::IE_UART]}};
		irq_nxt.otg = irq_i.otg & ie_r[pcr_pkg::IE_OTG]; // RULE17
		irq_nxt.inbound_mailbox_irq = irq_i.inbound_mailbox_irq & ie_r[pcr_pkg::IE_INBOUND_MAILBOX_IRQ];
		irq_nxt.outbound_mailbox_irq = irq_i.outbound_mailbox_irq & ie_r[pcr_pkg::IE_OUTBOUND_MAILBOX_IRQ];
		irq_nxt.gpio = irq_i.gpio & ie_r[pcr_pkg::IE_GPIO];
		irq_nxt.tm1 = irq_i.tm1 & ie_r[pcr_pkg::IE_TM1];
		irq_nxt.tm0 = irq_i.tm0 & ie_r[pcr_pkg::IE_TM0];
		any_irq = |irq_nxt;
		// core enable from divisor, only in run state
		if (pm_r == pcr_pkg::PM_RUN)
		begin
			if (cnt_r >= div_r[3:0]) // RULE2
				cnt_nxt = 4'h0;
			else
				cnt_nxt = cnt_r + 4'h1;
		end
		// breakpoint
		if ((brk_r != pcr_pkg::BRK_RESET) && (pc_i == brk_r) && cpu_run_r)
			brk_hit_nxt = 1'b1; // RULE19
		// power state machine
		case (pm_r)
			pcr_pkg::PM_RUN:
			begin
				if (pwr_r[pcr_pkg::PWR_SLEEP])
					pm_nxt = pcr_pkg::PM_SLEEP; // RULE3
				else if (pwr_r[pcr_pkg::PWR_HALT])
					pm_nxt = pcr_pkg::PM_HALT; // RULE6
			end
			pcr_pkg::PM_HALT:
			begin
				if (any_irq)
				begin
					pm_nxt = pcr_pkg::PM_RUN; // RULE7
					pwr_nxt[pcr_pkg::PWR_HALT] = 1'b0;
				end
			end
			pcr_pkg::PM_SLEEP:
			begin
				if (wake)
				begin
					pm_nxt = pcr_pkg::PM_WAKE; // RULE5
					pwr_nxt[pcr_pkg::PWR_SLEEP] = 1'b0;
					res_nxt = 16'(pcr_pkg::WAKE_CYC);
					discard_nxt = (pwr_r[pcr_pkg::PWR_FSP_WAKE] & edge_s[3])
						| (pwr_r[pcr_pkg::PWR_SPI_WAKE] & edge_s[4]
						& ~sync2_r[4]); // RULE12
				end
			end
			pcr_pkg::PM_WAKE:
			begin
				if (res_r == 16'h0000)
					pm_nxt = pcr_pkg::PM_RUN;
				else
					res_nxt = res_r - 16'h0001;
			end
			default:
				pm_nxt = pcr_pkg::PM_RUN;
		endcase
		// core enable only while staying in run
		cpu_run_nxt = (pm_r == pcr_pkg::PM_RUN)
			&& (pm_nxt == pcr_pkg::PM_RUN)
			&& (cnt_nxt == 4'h0); // RULE1
		// register writes
		if (req_i.wr)
		begin
			if (hit(pcr_pkg::ADDR_CLK_DIV))
				div_nxt = masked(req_i.wdata, pcr_pkg::CLK_DIV_MASK);
			if (hit(pcr_pkg::ADDR_PWR))
				pwr_nxt = masked(req_i.wdata, pcr_pkg::PWR_MASK)
					& ~(16'h0001 << pcr_pkg::PWR_BOOST);
			if (hit(pcr_pkg::ADDR_IRQ_EN))
			begin
				ie_nxt = masked(req_i.wdata, pcr_pkg::IRQ_EN_MASK);
				clr_nxt[0] = ~ie_nxt[pcr_pkg::IE_TM0]; // RULE18
				clr_nxt[1] = ~ie_nxt[pcr_pkg::IE_TM1];
				clr_nxt[2] = ~ie_nxt[pcr_pkg::IE_GPIO];
			end
			if (hit(pcr_pkg::ADDR_BRK))
			begin
				brk_nxt = req_i.wdata;
				if (req_i.wdata == pcr_pkg::BRK_RESET)
					brk_hit_nxt = 1'b0; // RULE26
			end
			if (hit(pcr_pkg::ADDR_DIAG))
				diag_nxt = masked(req_i.wdata, pcr_pkg::DIAG_MASK);
		end
		// register reads
		if (req_i.rd)
		begin
			rvalid_nxt = 1'b1;
			if (hit(pcr_pkg::ADDR_CLK_DIV))
				rdata_nxt = div_r;
			else if (hit(pcr_pkg::ADDR_PWR))
				rdata_nxt = pwr_r | ({15'h0000, sync2_r[7]}
					<< pcr_pkg::PWR_BOOST); // RULE14
			else if (hit(pcr_pkg::ADDR_IRQ_EN))
				rdata_nxt = ie_r;
			else if (hit(pcr_pkg::ADDR_BRK))
				rdata_nxt = brk_r;
			else if (hit(pcr_pkg::ADDR_DIAG) && !req_i.host)
				rdata_nxt = diag_r; // RULE20
			if (pm_r == pcr_pkg::PM_SLEEP)
				rdata_nxt = 16'h0000; // RULE25
		end
	end

	// ---------------------------------------------------------------
	// register stage
	// ---------------------------------------------------------------

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			div_r <= pcr_pkg::CLK_DIV_RESET;
			pwr_r <= pcr_pkg::PWR_RESET;
			ie_r <= pcr_pkg::IRQ_EN_RESET;
			brk_r <= pcr_pkg::BRK_RESET;
			diag_r <= pcr_pkg::DIAG_RESET;
			cnt_r <= 4'h0;
			res_r <= 16'h0000;
			pm_r <= pcr_pkg::PM_RUN;
			brk_hit_r <= 1'b0;
			rdata_o <= 16'h0000;
			rvalid_o <= 1'b0;
			cpu_run_r <= 1'b0;
			discard_r <= 1'b0;
			irq_o <= '0;
			clr_r <= 3'b000;
			jk_r <= 1'b0;
		end
		else
		begin
			div_r <= div_nxt;
			pwr_r <= pwr_nxt;
			ie_r <= ie_nxt;
			brk_r <= brk_nxt;
			diag_r <= diag_nxt;
			cnt_r <= cnt_nxt;
			res_r <= res_nxt;
			pm_r <= pm_nxt;
			brk_hit_r <= brk_hit_nxt;
			rdata_o <= rdata_nxt;
			rvalid_o <= rvalid_nxt;
			cpu_run_r <= cpu_run_nxt;
			discard_r <= discard_nxt;
			irq_o <= irq_nxt;
			clr_r <= clr_nxt;
			jk_r <= jk_nxt;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	logic awake_r;
	logic awake_nxt;
	pcr_pkg::pcr_line_s p1_r;
	pcr_pkg::pcr_line_s p2_r;
	pcr_pkg::pcr_line_s p1_nxt;
	pcr_pkg::pcr_line_s p2_nxt;
	pcr_pkg::pcr_line_s line_nxt;

	always_comb
	begin
		line_nxt.active = 1'b1;
		line_nxt.pull_down = diag_r[pcr_pkg::DG_PD]; // RULE22
		line_nxt.ls_pull_up = diag_r[pcr_pkg::DG_LS_PU];
		line_nxt.fs_pull_up = diag_r[pcr_pkg::DG_FS_PU];
		line_nxt.se0 = diag_r[pcr_pkg::DG_SE0]; // RULE23
		line_nxt.jk = ~diag_r[pcr_pkg::DG_SE0] & diag_r[pcr_pkg::DG_JK];
		line_nxt.j_not_k = jk_r;
		// peripherals, boost, pump and transceivers share one enable
		awake_nxt = (pm_nxt != pcr_pkg::PM_SLEEP); // RULE4
		p1_nxt = diag_r[pcr_pkg::DG_P1] ? line_nxt : '0; // RULE21
		p2_nxt = diag_r[pcr_pkg::DG_P2] ? line_nxt : '0;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			awake_r <= 1'b1;
			p1_r <= '0;
			p2_r <= '0;
		end
		else
		begin
			awake_r <= awake_nxt;
			p1_r <= p1_nxt;
			p2_r <= p2_nxt;
		end
	end

	assign cpu_run_o = cpu_run_r;
	assign periph_run_o = awake_r;
	assign breakpoint_vector_o = brk_hit_r;
	assign first_timer_clr_o = clr_r[0];
	assign second_timer_clr_o = clr_r[1];
	assign gpio_clr_o = clr_r[2];
	assign boost_on_o = awake_r;
	assign charge_pump_on_o = awake_r;
	assign transceiver_on_o = awake_r;
	assign discard_byte_o = discard_r;
	assign port1_line_o = p1_r;
	assign port2_line_o = p2_r;

endmodule

// >>> verification/pcr_cpu_model.sv
// processor model that steps the program counter
`timescale 1ns/1ps
module pcr_cpu_model
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// core enable and program counter
	input wire logic cpu_run_i,
	output logic [15:0] pc_o
);
	// ----
	// program counter
	// ----
	logic [15:0] pc_r;
	logic [15:0] pc_nxt;
	always_comb
	begin
		pc_nxt = pc_r;
		if (cpu_run_i)
			pc_nxt = pc_r + 16'h0001;
	end
	always_ff @(posedge sys_clk_i)
	begin
		pc_r <= reset_i ? 16'h0000 : pc_nxt;
	end
	assign pc_o = pc_r;
endmodule

// >>> verification/pcr_regs_chk.sv
// checker for the processor control register ports
`timescale 1ns/1ps
module pcr_regs_chk
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// watched ports
	input wire pcr_pkg::pcr_req_s req_i,
	input wire logic [15:0] rdata_o,
	input wire logic rvalid_o,
	input wire logic cpu_run_o,
	input wire logic periph_run_o,
	input wire logic breakpoint_vector_o,
	input wire pcr_pkg::pcr_irq_s irq_i,
	input wire pcr_pkg::pcr_irq_s irq_o,
	input wire logic first_timer_clr_o,
	input wire logic boost_on_o,
	input wire pcr_pkg::pcr_line_s port1_line_o,
	input wire pcr_pkg::pcr_line_s port2_line_o
);
	// ----
	// helpers
	// ----
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);
	logic [15:0] ie_r;
	logic [15:0] ie_nxt;
	wire wr_pwr = req_i.wr && req_i.addr == pcr_pkg::ADDR_PWR;
	wire wr_ien = req_i.wr && req_i.addr == pcr_pkg::ADDR_IRQ_EN;
	wire tm0_r = ie_r[pcr_pkg::IE_TM0];
	always_comb
	begin
		ie_nxt = wr_ien ? (req_i.wdata & pcr_pkg::IRQ_EN_MASK) : ie_r;
	end
	always_ff @(posedge sys_clk_i)
	begin
		ie_r <= reset_i ? 16'h0000 : ie_nxt;
	end
	sequence s_asleep;
		!periph_run_o && !boost_on_o && !cpu_run_o;
	endsequence
	sequence s_halted;
		!cpu_run_o && periph_run_o;
	endsequence
	// ----
	// assertions
	// ----
	chk_host_diag: assert property (
		req_i.rd && req_i.host && req_i.addr == pcr_pkg::ADDR_DIAG
		|=> rvalid_o && rdata_o == 16'h0000)
		else $error("host read of diag not zero");
	chk_irq_gated: assert property (
		(irq_o & ~$past(irq_i)) == '0)
		else $error("irq out without source");
	chk_irq_mask: assert property (
		irq_o.tm0 == ($past(irq_i.tm0) && $past(ie_r[pcr_pkg::IE_TM0]))
		&& irq_o.otg == ($past(irq_i.otg)
		&& $past(ie_r[pcr_pkg::IE_OTG]))
		&& irq_o.se1 == ($past(irq_i.se1)
		& {6{$past(ie_r[pcr_pkg::IE_SE1])}}))
		else $error("irq out not gated by enable");
	chk_timer_clear: assert property (
		wr_ien && tm0_r && !req_i.wdata[0] |-> ##[1:2] first_timer_clr_o)
		else $error("timer clear pulse missing");
	chk_sleep_entry: assert property (
		wr_pwr && req_i.wdata[1] |-> ##[1:5] s_asleep)
		else $error("sleep not entered");
	chk_sleep_freeze: assert property (
		!periph_run_o |-> !cpu_run_o)
		else $error("core ran while asleep");
	chk_halt_core: assert property (
		wr_pwr && req_i.wdata[1:0] == 2'b01 && irq_i == '0 && irq_o == '0
		|-> ##[2:5] s_halted)
		else $error("halt did not stop core only");
	chk_brk_clear: assert property (
		req_i.wr && req_i.addr == pcr_pkg::ADDR_BRK
		&& req_i.wdata == 16'h0000 |-> ##1 !breakpoint_vector_o [*4])
		else $error("breakpoint not cleared");
	chk_line_idle: assert property (
		(port1_line_o.active || port1_line_o == '0)
		&& (port2_line_o.active || port2_line_o == '0))
		else $error("idle port drives test state");
	chk_force_code: assert property (
		port1_line_o.se0 |-> !port1_line_o.jk)
		else $error("se0 and jk together");
	chk_jk_toggle: assert property (
		port2_line_o.jk && $past(port2_line_o.jk)
		|-> port2_line_o.j_not_k != $past(port2_line_o.j_not_k))
		else $error("jk state not toggling");
endmodule
bind pcr_regs pcr_regs_chk i_pcr_regs_chk (.sys_clk_i, .reset_i, .req_i,
	.rdata_o, .rvalid_o, .cpu_run_o, .periph_run_o, .breakpoint_vector_o,
	.irq_i, .irq_o, .first_timer_clr_o, .boost_on_o, .port1_line_o,
	.port2_line_o);

// >>> verification/testbench.sv
// testbench for the processor control register group
`timescale 1ns/1ps
module testbench;
	logic clk, rst, rv, run, prun, bv, c0, c1, cg, fsp, bno;
	logic bon, cp, tr, disc, se;
	logic [1:0] pw;
	logic [15:0] rdata, pc;
	pcr_pkg::pcr_req_s req;
	pcr_pkg::pcr_irq_s irq_i, irq_o;
	pcr_pkg::pcr_line_s l1, l2;
	int num_errors = 0;
	int samples_checked = 0;
	localparam logic [15:0] AD[4] = '{pcr_pkg::ADDR_CLK_DIV,
		pcr_pkg::ADDR_IRQ_EN, pcr_pkg::ADDR_BRK, pcr_pkg::ADDR_DIAG};
	localparam logic [15:0] MK[4] = '{pcr_pkg::CLK_DIV_MASK,
		pcr_pkg::IRQ_EN_MASK, 16'hffff, pcr_pkg::DIAG_MASK};
	localparam logic [15:0] RV[4] = '{pcr_pkg::CLK_DIV_RESET,
		pcr_pkg::IRQ_EN_RESET, pcr_pkg::BRK_RESET, pcr_pkg::DIAG_RESET};

	pcr_cpu_model i_pcr_cpu_model (.sys_clk_i(clk), .reset_i(rst),
		.cpu_run_i(run), .pc_o(pc));
	pcr_regs i_pcr_regs (.sys_clk_i(clk), .reset_i(rst), .req_i(req),
		.rdata_o(rdata), .rvalid_o(rv), .pc_i(pc), .cpu_run_o(run),
		.periph_run_o(prun), .breakpoint_vector_o(bv), .irq_i(irq_i),
		.irq_o(irq_o), .first_timer_clr_o(c0), .second_timer_clr_o(c1),
		.gpio_clr_o(cg), .se1_line_i(se), .se2_line_i(1'b0),
		.otg_vbus_valid_i(1'b0), .otg_id_i(1'b0),
		.fast_serial_port_rx_i(fsp), .serial_slave_select_n_i(1'b1),
		.pin_wake_i(pw), .boost_not_ok_i(bno), .boost_on_o(bon),
		.charge_pump_on_o(cp), .transceiver_on_o(tr),
		.discard_byte_o(disc), .port1_line_o(l1), .port2_line_o(l2));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----
	// shared tasks
	// ----
	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			num_errors++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask

	task automatic summarize;
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wr(input logic h, input logic [15:0] a,
		input logic [15:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, h, a, d};
		@(posedge clk);
		req <= '0;
	endtask

	task automatic rc(input string n, input logic h, input logic [15:0] a,
		input logic [15:0] e);
		@(posedge clk);
		req <= '{1'b0, 1'b1, h, a, 16'h0000};
		@(posedge clk);
		req <= '0;
		#1;
		chk(n, rdata, e);
	endtask

	task automatic wfor(input string n, ref logic s, input logic v,
		input int lim);
		for (int k = 0; k < lim && s !== v; k++)
		begin
			@(posedge clk);
			#1;
		end
		if (s !== v)
		begin
			num_errors++;
			$display("MISMATCH %s exp %h seen %h", n, v, s);
			summarize();
		end
	endtask

	task automatic cnt(output int n);
		n = 0;
		repeat (20)
		begin
			@(posedge clk);
			#1;
			if (run !== 1'b0)
				n++;
		end
	endtask

	function automatic pcr_pkg::pcr_irq_s gate(input logic [15:0] e);
		return '{{6{e[9]}}, {6{e[8]}}, {3{e[11]}}, {2{e[7]}},
			{2{e[3]}}, e[12], e[6], e[5], e[2], e[1], e[0]};
	endfunction

	// ----
	// scenarios
	// ----
	task automatic t_regs;
		rc("pwr", 0, pcr_pkg::ADDR_PWR, pcr_pkg::PWR_RESET);
		rc("unm", 0, 16'hc006, 16'h0000);
		chk("bv", bv, 1'b0);
		for (int k = 0; k < 4; k++)
		begin
			rc("rst", 0, AD[k], RV[k]);
			wr(0, AD[k], MK[k]);
			rc("rw", 0, AD[k], MK[k]);
			wr(0, AD[k], 16'h0000);
		end
	endtask

	task automatic t_div;
		int n;
		for (int k = 15; k >= 0; k -= 3)
		begin
			wr(0, pcr_pkg::ADDR_CLK_DIV, 16'(k));
			repeat (2)
			begin
				wfor("run", run, 1'b1, 40);
				n = 0;
				do
				begin
					@(posedge clk);
					#1;
					n++;
				end while (run !== 1'b1 && n < 40);
			end
			chk("div", n, k + 1);
			chk("per", prun, 1'b1);
		end
	endtask

	task automatic t_irq;
		logic [15:0] e;
		logic [2:0] s;
		@(posedge clk);
		irq_i <= '1;
		for (int k = 0; k < 13; k++)
		begin
			e = (16'h0001 << k) & pcr_pkg::IRQ_EN_MASK;
			wr(0, pcr_pkg::ADDR_IRQ_EN, e);
			repeat (2) @(posedge clk);
			#1;
			chk("irq", irq_o, gate(e));
		end
		wr(0, pcr_pkg::ADDR_IRQ_EN, 16'h0007);
		wr(0, pcr_pkg::ADDR_IRQ_EN, 16'h0000);
		s = 3'b000;
		repeat (3)
		begin
			#1;
			s |= {cg, c1, c0};
			@(posedge clk);
		end
		chk("clr", s, 3'b111);
		irq_i <= '0;
	endtask

	task automatic t_brk;
		logic [15:0] b;
		b = pc + 16'h0040;
		wr(0, pcr_pkg::ADDR_BRK, b);
		#1;
		chk("bv0", bv, 1'b0);
		wfor("bv", bv, 1'b1, 200);
		chk("hit", pc - b < 16'h0004, 1'b1);
		wr(0, pcr_pkg::ADDR_BRK, 16'h0000);
		@(posedge clk);
		#1;
		chk("bvc", bv, 1'b0);
	endtask

	task automatic t_diag;
		wr(0, pcr_pkg::ADDR_DIAG, 16'h1074);
		repeat (2) @(posedge clk);
		#1;
		chk("p1", l1[6:1], 6'h3e);
		chk("p2", l2, 7'h00);
		wr(1, pcr_pkg::ADDR_DIAG, 16'h4002);
		repeat (2) @(posedge clk);
		#1;
		chk("p1", l1, 7'h00);
		chk("p2", l2[6:1], 6'h21);
		rc("hd", 1, pcr_pkg::ADDR_DIAG, 16'h0000);
		rc("cd", 0, pcr_pkg::ADDR_DIAG, 16'h4002);
		wr(0, pcr_pkg::ADDR_DIAG, 16'h0000);
	endtask

	task automatic t_halt;
		int n;
		wr(0, pcr_pkg::ADDR_IRQ_EN, 16'h0001);
		wr(0, pcr_pkg::ADDR_PWR, 16'h0001);
		repeat (4) @(posedge clk);
		cnt(n);
		chk("halt", n, 0);
		chk("per", prun, 1'b1);
		@(posedge clk);
		irq_i.tm0 <= 1'b1;
		wfor("wake", run, 1'b1, 40);
		@(posedge clk);
		irq_i.tm0 <= 1'b0;
		rc("hb", 0, pcr_pkg::ADDR_PWR, 16'h0000);
		wr(0, pcr_pkg::ADDR_IRQ_EN, 16'h0000);
	endtask

	task automatic t_sleep;
		int n;
		wr(0, pcr_pkg::ADDR_PWR, 16'h0012);
		repeat (4) @(posedge clk);
		#1;
		chk("pwd", {prun, bon, cp, tr}, 4'h0);
		cnt(n);
		chk("frz", n, 0);
		rc("slp", 0, pcr_pkg::ADDR_PWR, 16'h0000);
		@(posedge clk);
		pw <= 2'b10;
		wfor("pwk", run, 1'b1, pcr_pkg::WAKE_CYC + 40);
		rc("pw", 0, pcr_pkg::ADDR_PWR, 16'h0010);
		wr(0, pcr_pkg::ADDR_PWR, 16'h0202);
		repeat (4) @(posedge clk);
		fsp <= 1'b1;
		wfor("dsc", disc, 1'b1, pcr_pkg::WAKE_CYC + 40);
		wfor("fwk", run, 1'b1, pcr_pkg::WAKE_CYC + 40);
		wr(0, pcr_pkg::ADDR_PWR, 16'h0082);
		repeat (4) @(posedge clk);
		rc("hrd", 1, pcr_pkg::ADDR_PWR, 16'h0000);
		wfor("hwk", run, 1'b1, pcr_pkg::WAKE_CYC + 40);
		@(posedge clk);
		bno <= 1'b1;
		repeat (4) @(posedge clk);
		rc("bst", 0, pcr_pkg::ADDR_PWR, 16'h0084);
		wr(0, pcr_pkg::ADDR_PWR, 16'h1002);
		repeat (4) @(posedge clk);
		se <= 1'b1;
		wfor("swk", run, 1'b1, pcr_pkg::WAKE_CYC + 40);
		chk("sirq", irq_o, '0);
		chk("sdsc", disc, 1'b0);
	endtask

	initial
	begin
		rst = 1'b1;
		req = '0;
		irq_i = '0;
		pw = 2'b00;
		fsp = 1'b0;
		se = 1'b0;
		bno = 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_div();
		t_irq();
		t_brk();
		t_diag();
		t_halt();
		t_sleep();
		summarize();
	end
endmodule
